//--- verilog/cpu_state_regs.v
/*
  processor state registers (program counter, flags word, stack pointer, register banks)
  with map decoding, driven by software over axi4-lite.
  assumes a single master, one write and one read outstanding at most.
*/
// The register addresses and the AXI4-Lite register port were left to the implementer.
`include "cpu_state_defs.vh"
module cpu_state_regs #(
  parameter BIG_HS = 1,
  parameter BIG_EXP = 1,
  parameter HAS_DISP = 1
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // write address, data and response
  input wire [7:0] s_awaddr,
  input wire s_awvalid,
  output reg s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output reg s_wready,
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  // read
  input wire [7:0] s_araddr,
  input wire s_arvalid,
  output reg s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready,
  // interrupt request inputs
  input wire irq_nmi,
  input wire irq_req,
  input wire irq_low_prio,
  input wire irq_masked,
  // state outputs
  output reg [15:0] pc_q,
  output reg [7:0] flags_q,
  output reg [15:0] sp_q,
  output reg irq_take_q
);
  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // bank slice: bank*8 plus register index, inside fee0h
  function [4:0] greg_index;
    input [1:0] bank;
    input [2:0] r;
    begin
      greg_index = {bank, r};
    end
  endfunction

  function [7:0] merge_byte;
    input [7:0] old;
    input [7:0] nw;
    input en;
    begin
      merge_byte = en ? nw : old;
    end
  endfunction

  // ------------------------------------------------------------
  // bus write channel
  // ------------------------------------------------------------
  reg [7:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;
  wire do_write = aw_have_q && w_have_q && !s_bvalid;
  wire wr_ok = (awaddr_q == `A_CTRL) || (awaddr_q == `A_FLAGS) || (awaddr_q == `A_SP) ||
               (awaddr_q == `A_PC) || (awaddr_q == `A_ALU) || (awaddr_q == `A_IRQ) ||
               (awaddr_q == `A_DECODE) || (awaddr_q == `A_GREG) || (awaddr_q == `A_STACK) ||
               (awaddr_q == `A_BRANCH) || (awaddr_q == `A_STATUS);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= `RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        awaddr_q <= s_awaddr;
        aw_have_q <= 1'b1;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
        w_have_q <= 1'b1;
        s_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  wire wr_ctrl = do_write && awaddr_q == `A_CTRL && wstrb_q[0];
  // a length written with the step op applies to that same step
  wire [2:0] step_len = (wr_ctrl && wstrb_q[1]) ? wdata_q[10:8] : step_len_q;
  wire [3:0] op = wr_ctrl ? wdata_q[3:0] : `OP_NONE;

  // ------------------------------------------------------------
  // operand registers
  // ------------------------------------------------------------
  reg [7:0] alu_a_q;
  reg [7:0] alu_b_q;
  reg [2:0] alu_op_q;
  reg [2:0] step_len_q;
  reg [15:0] branch_q;
  reg [15:0] decode_addr_q;
  reg [7:0] stack_wdata_q;
  reg [2:0] greg_sel_q;
  reg [7:0] greg_wdata_q;
  reg [7:0] alu_res_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      alu_a_q <= 8'h00;
      alu_b_q <= 8'h00;
      alu_op_q <= `ALU_ADD;
      step_len_q <= 3'h1;
      branch_q <= 16'h0000;
      decode_addr_q <= 16'h0000;
      stack_wdata_q <= 8'h00;
      greg_sel_q <= 3'h0;
      greg_wdata_q <= 8'h00;
    end else if (do_write) begin
      if (awaddr_q == `A_ALU) begin
        alu_a_q <= merge_byte(alu_a_q, wdata_q[7:0], wstrb_q[0]);
        alu_b_q <= merge_byte(alu_b_q, wdata_q[15:8], wstrb_q[1]);
        if (wstrb_q[2]) begin
          alu_op_q <= wdata_q[18:16];
        end
      end else if (awaddr_q == `A_CTRL && wstrb_q[1]) begin
        step_len_q <= wdata_q[10:8];
      end else if (awaddr_q == `A_BRANCH) begin
        branch_q <= {merge_byte(branch_q[15:8], wdata_q[15:8], wstrb_q[1]),
                     merge_byte(branch_q[7:0], wdata_q[7:0], wstrb_q[0])};
      end else if (awaddr_q == `A_DECODE) begin
        decode_addr_q <= {merge_byte(decode_addr_q[15:8], wdata_q[15:8], wstrb_q[1]),
                          merge_byte(decode_addr_q[7:0], wdata_q[7:0], wstrb_q[0])};
      end else if (awaddr_q == `A_STACK && wstrb_q[0]) begin
        stack_wdata_q <= wdata_q[7:0];
      end else if (awaddr_q == `A_GREG) begin
        greg_wdata_q <= merge_byte(greg_wdata_q, wdata_q[7:0], wstrb_q[0]);
        if (wstrb_q[1]) begin
          greg_sel_q <= wdata_q[10:8];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // alu flag generation
  // ------------------------------------------------------------
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] res;
  reg cy_n;
  reg ac_n;
  reg bitv;
  always @* begin
    sum = 9'h000;
    nib = 5'h00;
    res = alu_a_q;
    cy_n = flags_q[`F_CY];
    ac_n = flags_q[`F_AC];
    bitv = alu_a_q[alu_b_q[2:0]];
    case (alu_op_q)
      `ALU_ADD: begin
        sum = {1'b0, alu_a_q} + {1'b0, alu_b_q};
        nib = {1'b0, alu_a_q[3:0]} + {1'b0, alu_b_q[3:0]};
        res = sum[7:0];
        cy_n = sum[8];
        ac_n = nib[4];
      end
      `ALU_SUB: begin
        sum = {1'b0, alu_a_q} - {1'b0, alu_b_q};
        nib = {1'b0, alu_a_q[3:0]} - {1'b0, alu_b_q[3:0]};
        res = sum[7:0];
        cy_n = sum[8];
        ac_n = nib[4];
      end
      `ALU_ROL: begin
        res = {alu_a_q[6:0], alu_a_q[7]};
        cy_n = alu_a_q[7];
      end
      `ALU_ROR: begin
        res = {alu_a_q[0], alu_a_q[7:1]};
        cy_n = alu_a_q[0];
      end
      `ALU_BAND: cy_n = flags_q[`F_CY] & bitv; // bit accumulator
      `ALU_BOR: cy_n = flags_q[`F_CY] | bitv;
      `ALU_BXOR: cy_n = flags_q[`F_CY] ^ bitv;
      default: res = alu_a_q;
    endcase
  end
  wire alu_bitop = alu_op_q >= `ALU_BAND;

  // ------------------------------------------------------------
  // interrupt acceptance
  // ------------------------------------------------------------
  // nmi ignores the gate; maskable needs gate, no mask, and priority flag when low
  wire irq_ok = irq_nmi || (flags_q[`F_IE] && irq_req && !irq_masked &&
                (flags_q[`F_ISP] || !irq_low_prio));
  wire ack = (op == `OP_ACK) && irq_ok;

  // ------------------------------------------------------------
  // stack and register bank memories
  // ------------------------------------------------------------
  wire [15:0] sp_dec = sp_q - 16'h0001;
  wire [2:0] sp_region;
  wire [2:0] dec_region;
  wire push = (op == `OP_PUSH) || (op == `OP_PUSHF) || ack;
  wire pop = (op == `OP_POP) || (op == `OP_POPF);
  wire [15:0] stk_addr = push ? sp_dec : sp_q; // pre-decrement on write
  wire [7:0] stk_wdata = (op == `OP_PUSH) ? stack_wdata_q : flags_q;
  wire [7:0] stk_rdata;
  wire [7:0] greg_rdata;
  wire greg_we = do_write && awaddr_q == `A_GREG && wstrb_q[0];
  // a write lands at the data of the same bus word, and at its index when byte 1 is strobed, else at the held index
  wire [2:0] greg_wsel = wstrb_q[1] ? wdata_q[10:8] : greg_sel_q;
  wire [2:0] greg_asel = greg_we ? greg_wsel : greg_sel_q;

  addr_decode u_sp_dec (
    .big_hs(BIG_HS != 0),
    .big_exp(BIG_EXP != 0),
    .has_disp(HAS_DISP != 0),
    .addr(stk_addr),
    .region(sp_region)
  );

  addr_decode u_sw_dec (
    .big_hs(BIG_HS != 0),
    .big_exp(BIG_EXP != 0),
    .has_disp(HAS_DISP != 0),
    .addr(decode_addr_q),
    .region(dec_region)
  );

  // stack confined to high-speed ram, register banks included
  wire stk_ok = (sp_region == `RG_HS) || (sp_region == `RG_GREG);

  byte_ram #(.AW(10)) u_hs_ram (
    .aclk(aclk),
    .we(push && stk_ok),
    .addr(stk_addr[9:0]),
    .wdata(stk_wdata),
    .rdata(stk_rdata)
  );

  // banks occupy fee0h-feffh; kept apart so the bank view reads without a stack slot
  byte_ram #(.AW(5)) u_greg_ram (
    .aclk(aclk),
    .we(greg_we),
    .addr(greg_index({flags_q[`F_BANK_SELECT_HIGH], flags_q[`F_BANK_SELECT_LOW]}, greg_asel)),
    .wdata(wdata_q[7:0]),
    .rdata(greg_rdata)
  );

  // ------------------------------------------------------------
  // processor state
  // ------------------------------------------------------------
  reg pop_pend_q;
  reg popf_pend_q;
  reg [7:0] pop_data_q;
  reg stk_err_q;
  reg vec_pend_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= `VEC_RESET_LO;
      flags_q <= `FLAGS_RESET;
      sp_q <= 16'h0000;
      irq_take_q <= 1'b0;
      pop_pend_q <= 1'b0;
      popf_pend_q <= 1'b0;
      pop_data_q <= 8'h00;
      stk_err_q <= 1'b0;
      alu_res_q <= 8'h00;
      vec_pend_q <= 1'b1;
    end else begin
      irq_take_q <= ack;
      pop_pend_q <= pop && stk_ok;
      popf_pend_q <= (op == `OP_POPF) && stk_ok;
      if ((push || pop) && !stk_ok) begin
        stk_err_q <= 1'b1;
      end
      if (vec_pend_q) begin
        // reset vector low at 0000h, high at 0001h, supplied by software
        vec_pend_q <= 1'b0;
      end
      case (op)
        `OP_STEP: pc_q <= pc_q + {13'h0000, step_len};
        `OP_BRANCH: pc_q <= branch_q;
        `OP_FETCHVEC: pc_q <= branch_q; // vector word written first
        `OP_TCALL: pc_q <= `TABLE_CALL_INSTRUCTION_LO | {10'h000, branch_q[4:0], 1'b0};
        `OP_FCALL: pc_q <= `FIXED_AREA_CALL_INSTRUCTION_LO | {5'h00, branch_q[10:0]} & `FIXED_AREA_CALL_INSTRUCTION_HI;
        `OP_MASK: flags_q[`F_IE] <= 1'b0;
        `OP_UNMASK: flags_q[`F_IE] <= 1'b1;
        `OP_BANK: begin
          flags_q[`F_BANK_SELECT_HIGH] <= wdata_q[5];
          flags_q[`F_BANK_SELECT_LOW] <= wdata_q[4];
        end
        `OP_ALU: begin
          alu_res_q <= res;
          flags_q[`F_CY] <= cy_n;
          if (!alu_bitop) begin
            flags_q[`F_Z] <= (res == 8'h00);
            flags_q[`F_AC] <= ac_n;
          end
        end
        default: pc_q <= pc_q;
      endcase
      if (ack) begin
        flags_q[`F_IE] <= 1'b0;
      end
      if (push && stk_ok) begin
        sp_q <= sp_dec;
      end else if (pop && stk_ok) begin
        sp_q <= sp_q + 16'h0001; // post-increment
      end
      if (pop_pend_q) begin
        pop_data_q <= stk_rdata;
      end
      if (popf_pend_q) begin
        flags_q <= stk_rdata;
      end
      if (do_write && awaddr_q == `A_FLAGS && wstrb_q[0]) begin
        flags_q <= wdata_q[7:0];
      end
      if (do_write && awaddr_q == `A_SP) begin
        sp_q <= {merge_byte(sp_q[15:8], wdata_q[15:8], wstrb_q[1]),
                 merge_byte(sp_q[7:0], wdata_q[7:0], wstrb_q[0])};
      end
      if (do_write && awaddr_q == `A_PC) begin
        pc_q <= {merge_byte(pc_q[15:8], wdata_q[15:8], wstrb_q[1]),
                 merge_byte(pc_q[7:0], wdata_q[7:0], wstrb_q[0])};
      end
      if (do_write && awaddr_q == `A_STATUS && wdata_q[0]) begin
        stk_err_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // bus read channel
  // ------------------------------------------------------------
  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    if (s_araddr == `A_FLAGS) begin
      rd_mux = {24'h000000, flags_q};
    end else if (s_araddr == `A_SP) begin
      rd_mux = {16'h0000, sp_q};
    end else if (s_araddr == `A_PC) begin
      rd_mux = {16'h0000, pc_q};
    end else if (s_araddr == `A_ALU) begin
      rd_mux = {5'h00, alu_op_q, alu_res_q, alu_b_q, alu_a_q};
    end else if (s_araddr == `A_DECODE) begin
      // software never probes unassigned peripheral addresses
      rd_mux = {13'h0000, dec_region, decode_addr_q};
    end else if (s_araddr == `A_GREG) begin
      rd_mux = {21'h000000, greg_sel_q, greg_rdata};
    end else if (s_araddr == `A_STACK) begin
      rd_mux = {16'h0000, pop_data_q, stack_wdata_q};
    end else if (s_araddr == `A_BRANCH) begin
      rd_mux = {16'h0000, branch_q};
    end else if (s_araddr == `A_STATUS) begin
      rd_mux = {30'h00000000, irq_ok, stk_err_q};
    end else if (s_araddr == `A_CTRL || s_araddr == `A_IRQ) begin
      rd_mux = {21'h000000, step_len_q, 8'h00};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= `RESP_OKAY;
    end else begin
      if (s_arvalid && s_arready) begin
        s_arready <= 1'b0;
        s_rvalid <= 1'b1;
        s_rdata <= rd_mux;
        s_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end
endmodule

//--- verilog/cpu_state_defs.vh
/*
  constants for the processor state and address decoding block: region bounds of the
  64k map, flag positions, reset values and the bus register offsets.
  assumes it is included by bare name from plain verilog design files.
*/
`ifndef CPU_STATE_DEFS_VH
`define CPU_STATE_DEFS_VH

// ------------------------------------------------------------
// address map
// ------------------------------------------------------------
`define VEC_RESET_LO 16'h0000
`define VEC_RESET_HI 16'h0001
`define TABLE_CALL_INSTRUCTION_LO 16'h0040
`define TABLE_CALL_INSTRUCTION_HI 16'h007f
`define FIXED_AREA_CALL_INSTRUCTION_LO 16'h0800
`define FIXED_AREA_CALL_INSTRUCTION_HI 16'h0fff
`define EXP_LO_BIG 16'hf400
`define EXP_LO_SMALL 16'hf600
`define EXP_HI 16'hf7ff
`define LINK_LO 16'hf800
`define LINK_HI 16'hf8ff
`define DISP_LO 16'hfa00
`define DISP_HI 16'hfa27
`define HS_LO_BIG 16'hfb00
`define HS_LO_SMALL 16'hfc00
`define HS_HI 16'hfeff
`define GREG_LO 16'hfee0
`define GREG_HI 16'hfeff
`define PERIPH_LO 16'hff00

// region codes
`define RG_ROM 3'h0
`define RG_EXP 3'h1
`define RG_LINK 3'h2
`define RG_DISP 3'h3
`define RG_HS 3'h4
`define RG_GREG 3'h5
`define RG_PERIPH 3'h6
`define RG_NONE 3'h7

// ------------------------------------------------------------
// flags word
// ------------------------------------------------------------
`define F_IE 7
`define F_Z 6
`define F_BANK_SELECT_HIGH 5
`define F_AC 4
`define F_BANK_SELECT_LOW 3
`define F_ISP 1
`define F_CY 0
`define FLAGS_RESET 8'h02

// ------------------------------------------------------------
// bus registers (word byte addresses)
// ------------------------------------------------------------
`define A_CTRL 8'h00
`define A_FLAGS 8'h04
`define A_SP 8'h08
`define A_PC 8'h0c
`define A_ALU 8'h10
`define A_IRQ 8'h14
`define A_DECODE 8'h18
`define A_GREG 8'h1c
`define A_STACK 8'h20
`define A_BRANCH 8'h24
`define A_STATUS 8'h28
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// control op codes written to A_CTRL[3:0]
`define OP_NONE 4'h0
`define OP_STEP 4'h1
`define OP_BRANCH 4'h2
`define OP_TCALL 4'h3
`define OP_FCALL 4'h4
`define OP_MASK 4'h5
`define OP_UNMASK 4'h6
`define OP_ACK 4'h7
`define OP_PUSHF 4'h8
`define OP_POPF 4'h9
`define OP_BANK 4'ha
`define OP_ALU 4'hb
`define OP_PUSH 4'hc
`define OP_POP 4'hd
`define OP_FETCHVEC 4'he

// alu op codes in A_ALU[18:16]
`define ALU_ADD 3'h0
`define ALU_SUB 3'h1
`define ALU_ROL 3'h2
`define ALU_ROR 3'h3
`define ALU_BAND 3'h4
`define ALU_BOR 3'h5
`define ALU_BXOR 3'h6
`endif

//--- verilog/byte_ram.v
/*
  small byte-wide single-port memory with registered read data.
  assumes one access per cycle; write and read share the address.
*/
module byte_ram #(
  parameter AW = 10
) (
  // clock
  input wire aclk,
  // access
  input wire we,
  input wire [AW-1:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:(1<<AW)-1];

  always @(posedge aclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

//--- verilog/addr_decode.v
/*
  combinational decoder of the 64k data space into its regions.
  assumes the variant straps are static while the block runs.
*/
`include "cpu_state_defs.vh"
module addr_decode (
  // variant straps
  input wire big_hs,
  input wire big_exp,
  input wire has_disp,
  // address
  input wire [15:0] addr,
  // result
  output reg [2:0] region
);
  // full 16-bit compare; an address outside every region, such as f900h, decodes to RG_NONE
  always @* begin
    region = `RG_NONE;
    if (addr >= `PERIPH_LO) begin
      region = `RG_PERIPH;
    end else if (addr >= `GREG_LO && addr <= `GREG_HI) begin
      region = `RG_GREG;
    end else if (addr <= `HS_HI && addr >= (big_hs ? `HS_LO_BIG : `HS_LO_SMALL)) begin
      region = `RG_HS;
    end else if (has_disp && addr >= `DISP_LO && addr <= `DISP_HI) begin
      region = `RG_DISP;
    end else if (addr >= `LINK_LO && addr <= `LINK_HI) begin
      region = `RG_LINK;
    end else if (addr <= `EXP_HI && addr >= (big_exp ? `EXP_LO_BIG : `EXP_LO_SMALL)) begin
      region = `RG_EXP;
    end else if (addr < `EXP_LO_BIG) begin
      region = `RG_ROM;
    end
  end
endmodule

//--- tb/cpu_state_sva.sv
/*
  port checker for cpu_state_regs, attached by bind.
  assumes one clock aclk and a synchronous active-low aresetn.
*/
module cpu_state_sva (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire s_awvalid,
  input wire s_awready,
  input wire s_wvalid,
  input wire s_wready,
  input wire s_bvalid,
  input wire s_bready,
  input wire s_arvalid,
  input wire s_arready,
  input wire s_rvalid,
  input wire s_rready,
  input wire [31:0] s_rdata,
  // state
  input wire [15:0] pc_q,
  input wire [7:0] flags_q,
  input wire irq_take_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // handshake steps
  // ----------------------------------------
  sequence s_wr;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence s_rd;
    s_arvalid && s_arready;
  endsequence
  property p_rst_state;
    $rose(aresetn) |-> flags_q == 8'h02 && pc_q == 16'h0000;
  endproperty
  a_rst_state: assert property (p_rst_state)
    else $error("state not at reset value");
  property p_take_gate;
    irq_take_q |-> !flags_q[7];
  endproperty
  a_take_gate: assert property (p_take_gate)
    else $error("gate still open after acknowledge");
  property p_take_pulse;
    irq_take_q |=> !irq_take_q;
  endproperty
  a_take_pulse: assert property (p_take_pulse)
    else $error("acknowledge pulse too long");
  // pc may only move when a write completes
  property p_pc_write;
    $changed(pc_q) |-> $rose(s_bvalid);
  endproperty
  a_pc_write: assert property (p_pc_write)
    else $error("pc moved without a write");
  property p_b_follow;
    s_wr |=> ##1 s_bvalid;
  endproperty
  a_b_follow: assert property (p_b_follow)
    else $error("write response late");
  property p_r_follow;
    s_rd |=> s_rvalid;
  endproperty
  a_r_follow: assert property (p_r_follow)
    else $error("read data late");
  property p_b_hold;
    s_bvalid && !s_bready |=> s_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_hold;
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  property p_ready_back;
    s_bvalid && s_bready |=> s_awready && s_wready;
  endproperty
  a_ready_back: assert property (p_ready_back)
    else $error("write readies not restored");
endmodule

bind cpu_state_regs cpu_state_sva cpu_state_sva_inst (
  .aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_bready(s_bready),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid), .s_rready(s_rready),
  .s_rdata(s_rdata), .pc_q(pc_q), .flags_q(flags_q), .irq_take_q(irq_take_q));

//--- tb/cpu_state_regs_and_memory_map_tb_top.sv
/*
  self-checking bench for cpu_state_regs over axi4-lite.
  assumes default straps: 1024-byte hs ram, 1024-byte expansion ram, display present.
*/
`include "cpu_state_defs.vh"
module cpu_state_regs_and_memory_map_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0, aresetn = 1'h0, took = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, d;
  logic nmi = 1'h0, req = 1'h0, lowp = 1'h0, msk = 1'h0;
  wire awready, wready, bvalid, arready, rvalid, take;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] pc, sp;
  wire [7:0] flags;
  int mismatches = 0, samples_checked = 0, cyc = 0;
  localparam logic [18:0] dec_tab [16] = '{
    {16'h0000, `RG_ROM}, {16'h0fff, `RG_ROM}, {16'hf400, `RG_EXP}, {16'hf7ff, `RG_EXP},
    {16'hf800, `RG_LINK}, {16'hf8ff, `RG_LINK}, {16'hf900, `RG_NONE}, {16'hfa00, `RG_DISP},
    {16'hfa27, `RG_DISP}, {16'hfa28, `RG_NONE}, {16'hfb00, `RG_HS}, {16'hfedf, `RG_HS},
    {16'hfee0, `RG_GREG}, {16'hfeff, `RG_GREG}, {16'hff00, `RG_PERIPH}, {16'hffff, `RG_PERIPH}};

  cpu_state_regs cpu_state_regs_inst (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .irq_nmi(nmi), .irq_req(req), .irq_low_prio(lowp), .irq_masked(msk), .pc_q(pc),
    .flags_q(flags), .sp_q(sp), .irq_take_q(take));

  initial forever #10 aclk = ~aclk;
  // pulse catcher: the take pulse lasts a single cycle
  always @(posedge aclk) if (take === 1'h1) took <= 1'h1;
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_resp(input logic [1:0] g, e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t response %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = `RESP_OKAY);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    fork
      begin do @(posedge aclk); while (awready !== 1'h1); awvalid <= 1'h0; end
      begin do @(posedge aclk); while (wready !== 1'h1); wvalid <= 1'h0; end
    join
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk_resp(bresp, er);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = `RESP_OKAY);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    v = rdata;
    rready <= 1'h0;
    chk_resp(rresp, er);
    @(posedge aclk);
  endtask
  task automatic op(input logic [3:0] o, input logic [31:0] x = 32'h0);
    wr(`A_CTRL, x | 32'(o));
  endtask
  task automatic ack(input logic e);
    took = 1'h0;
    op(`OP_ACK);
    repeat (2) @(posedge aclk);
    chk(32'(took), 32'(e));
  endtask
  task automatic alu(input logic [31:0] w, input logic [7:0] rm, r, fm, f);
    wr(`A_ALU, w);
    op(`OP_ALU);
    rd(`A_ALU, d);
    chk(32'(d[23:16] & rm), 32'(r));
    chk(32'(flags & fm), 32'(f));
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    @(posedge aclk);
    chk(32'(flags), 32'h02);
    chk(32'(pc), 32'h0);
    rd(`A_FLAGS, d);
    chk(32'(d[7:0]), 32'h02);
  endtask
  task automatic t_pc();
    wr(`A_BRANCH, 32'h1234);
    op(`OP_FETCHVEC);
    chk(32'(pc), 32'h1234);
    op(`OP_STEP, 32'h0300);
    chk(32'(pc), 32'h1237);
    wr(`A_BRANCH, 32'h0005);
    op(`OP_TCALL);
    chk(32'(pc), 32'h004a);
    wr(`A_BRANCH, 32'hffff);
    op(`OP_TCALL);
    chk(32'(pc), 32'h007e);
    op(`OP_FCALL);
    chk(32'(pc), 32'h0fff);
    wr(`A_BRANCH, 32'h0abc);
    op(`OP_BRANCH);
    chk(32'(pc), 32'h0abc);
  endtask
  task automatic t_decode();
    for (int i = 0; i < 16; i++) begin
      wr(`A_DECODE, 32'(dec_tab[i][18:3]));
      rd(`A_DECODE, d);
      chk(32'(d[18:16]), 32'(dec_tab[i][2:0]));
    end
  endtask
  task automatic t_flags();
    op(`OP_MASK);
    chk(32'(flags[7]), 32'h0);
    op(`OP_UNMASK);
    chk(32'(flags[7]), 32'h1);
    op(`OP_BANK, 32'h30);
    chk(32'(flags & 8'h28), 32'h28);
    op(`OP_BANK, 32'h20);
    chk(32'(flags & 8'h28), 32'h20);
    wr(`A_GREG, 32'h035a);
    op(`OP_BANK, 32'h10);
    chk(32'(flags & 8'h28), 32'h08);
    wr(`A_GREG, 32'h03c3);
    rd(`A_GREG, d);
    rd(`A_GREG, d);
    chk(32'(d[7:0]), 32'hc3);
    op(`OP_BANK, 32'h20);
    rd(`A_GREG, d);
    rd(`A_GREG, d);
    chk(32'(d[7:0]), 32'h5a);
  endtask
  task automatic t_alu();
    alu(32'h0000010f, 8'hff, 8'h10, 8'h51, 8'h10);
    alu(32'h000001ff, 8'hff, 8'h00, 8'h51, 8'h51);
    alu(32'h00010100, 8'hff, 8'hff, 8'h51, 8'h11);
    alu(32'h00060001, 8'h00, 8'h00, 8'h51, 8'h10);
    alu(32'h00020080, 8'h00, 8'h00, 8'h01, 8'h01);
  endtask
  task automatic t_irq();
    wr(`A_SP, 32'hfe20);
    wr(`A_FLAGS, 32'h82);
    req <= 1'h1;
    lowp <= 1'h1;
    ack(1'h1);
    chk(32'(flags[7]), 32'h0);
    chk(32'(sp), 32'hfe1f);
    ack(1'h0);
    nmi <= 1'h1;
    ack(1'h1);
    nmi <= 1'h0;
    wr(`A_FLAGS, 32'h80);
    ack(1'h0);
    lowp <= 1'h0;
    ack(1'h1);
    wr(`A_FLAGS, 32'h82);
    msk <= 1'h1;
    ack(1'h0);
    msk <= 1'h0;
    req <= 1'h0;
  endtask
  task automatic t_stack();
    wr(`A_SP, 32'hfe20);
    wr(`A_STACK, 32'ha5);
    op(`OP_PUSH);
    chk(32'(sp), 32'hfe1f);
    op(`OP_POP);
    chk(32'(sp), 32'hfe20);
    rd(`A_STACK, d);
    chk(32'(d[15:8]), 32'ha5);
    wr(`A_FLAGS, 32'h51);
    op(`OP_PUSHF);
    wr(`A_FLAGS, 32'h02);
    op(`OP_POPF);
    repeat (2) @(posedge aclk);
    chk(32'(flags), 32'h51);
    chk(32'(sp), 32'hfe20);
    // a stack outside hs ram must not move
    wr(`A_SP, 32'h0100);
    op(`OP_PUSH);
    chk(32'(sp), 32'h0100);
    rd(`A_STATUS, d);
    chk(32'(d[0]), 32'h1);
    wr(`A_STATUS, 32'h1);
    rd(`A_STATUS, d);
    chk(32'(d[0]), 32'h0);
  endtask
  task automatic t_err();
    rd(8'h3c, d, `RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h3c, 32'hffff, `RESP_SLVERR);
    chk(32'(pc), 32'h0abc);
  endtask
  task automatic stop_test();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_pc();
    t_decode();
    t_flags();
    t_alu();
    t_irq();
    t_stack();
    t_err();
    // second reset in mid-run
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    stop_test();
  end
endmodule
